// File: nvs_pkg.sv
// Contract
// [RULE1] Device reads when select and output drive low, write strobe and busy high.
// [RULE2] Address picks one of 524,288 bytes or 262,144 words.
// [RULE3] In x16 reads, byte lane enables pick driven byte halves; the model drives both halves and inverts a disabled one.
// [RULE4] Selected read output follows address changes without control transitions.
// [RULE5] Device writes when select and write strobe low, busy high.
// [RULE6] Host holds address stable from before write start until write end.
// [RULE7] Data captured at rising edge ending the write; host holds data before it.
// [RULE8] In x16 writes only enabled byte halves change.
// [RULE9] Host keeps output drive high during the whole write.
// [RULE10] Device turns off outputs shortly after write strobe falls if drive low.
// [RULE11] Device blocks reads and writes during store or recall.
// [RULE12] Store starts from pin, software sequence or power fail; auto enabled.
// [RULE13] Power fail starts automatic store when enabled.
// [RULE14] Auto and pin stores ignored unless a write occurred since last store.
// [RULE15] Software store runs regardless of prior writes.
// [RULE16] Pulling busy pin low starts conditional store after request delay.
// [RULE17] Device drives busy pin low for the whole store.
// [RULE18] Accesses in progress when busy falls are allowed to finish; the model finishes writes only, and its read output turns off at once.
// [RULE19] Writes requested after busy falls are refused until it rises.
// [RULE20] Without prior write, device does not drive busy but blocks until released.
// [RULE21] After store, device stays disabled until busy pin seen high.
// [RULE22] Select high deselects; no access accepted while deselected.
// [RULE23] Output drive high puts data pins in high impedance.
// [RULE24] Device drives busy pin high briefly at store end; the model only releases busy_pull and leaves the pull-up to raise it.
// [RULE25] Device write-pending flag set by writes, cleared by store completion.
package nvs_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    // Phase lengths in clock cycles at 20 MHz; one phase is 50 ns.
    localparam int CLK_NS      = 50;
    localparam int SETUP_NS    = 50;
    localparam int STROBE_NS   = 100;
    localparam int HOLD_NS     = 50;
    localparam int SETUP_CYC   = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC    = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    // Two extra strobe cycles let read data pass the two-flop synchroniser.
    localparam int SYNC_CYC    = 2;
    localparam int CNT_W       = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
    typedef enum logic [2:0] {
        NVS_IDLE   = 3'b000,
        NVS_SETUP  = 3'b001,
        NVS_STROBE = 3'b010,
        NVS_HOLD   = 3'b011,
        NVS_REQ    = 3'b100,
        NVS_WAITHI = 3'b101
    } nvs_state_e;
endpackage

// File: nvs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module nvs_sync (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rstn,
    // Asynchronous level in, synchronous level out.
    input  wire logic din,
    output logic      dout
);
    logic meta;
    logic next_meta;
    logic next_dout;

    always_comb begin
        next_meta = din;
        next_dout = meta;
    end

    // Resets high because the pin idles high on its pull-up.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= 1'b1;
            dout <= 1'b1;
        end else begin
            meta <= next_meta;
            dout <= next_dout;
        end
    end
endmodule
`default_nettype wire

// File: nvs_host.sv
`timescale 1ns/1ps
`default_nettype none
module nvs_host (
    // Clock and reset.
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // User request port.
    input  wire logic                      req_valid,
    input  wire logic                      req_write,
    input  wire logic [nvs_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [nvs_pkg::DATA_W-1:0] req_wdata,
    input  wire logic [1:0]                req_lanes,
    input  wire logic                      store_req,
    output logic                           req_ready,
    output logic                           rsp_valid,
    output logic [nvs_pkg::DATA_W-1:0]     rsp_rdata,
    output logic                           store_busy,
    // Memory pins.
    output logic [nvs_pkg::ADDR_W-1:0]     mem_addr,
    output logic                           chip_select_n,
    output logic                           write_strobe_n,
    output logic                           output_drive_n,
    output logic                           upper_byte_lane_n,
    output logic                           lower_byte_lane_n,
    input  wire logic [nvs_pkg::DATA_W-1:0] dq_in,
    output logic [nvs_pkg::DATA_W-1:0]     dq_out,
    output logic                           dq_oe,
    input  wire logic                      store_busy_request_n_in,
    output logic                           store_busy_request_n_out,
    output logic                           store_busy_request_n_oe
);
    // ------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------
    logic                       busy_hi;
    logic [nvs_pkg::DATA_W-1:0] dq_s1;
    logic [nvs_pkg::DATA_W-1:0] dq_s2;
    logic [nvs_pkg::DATA_W-1:0] next_dq_s1;
    logic [nvs_pkg::DATA_W-1:0] next_dq_s2;

    nvs_sync u_busy_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  (store_busy_request_n_in),
        .dout (busy_hi)
    );

    always_comb begin
        next_dq_s1 = dq_in;
        next_dq_s2 = dq_s1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
        end else begin
            dq_s1 <= next_dq_s1;
            dq_s2 <= next_dq_s2;
        end
    end

    // ------------------------------------------------------------
    // Access sequencer.
    // ------------------------------------------------------------
    nvs_pkg::nvs_state_e        state;
    nvs_pkg::nvs_state_e        next_state;
    logic [nvs_pkg::CNT_W-1:0]  cnt;
    logic [nvs_pkg::CNT_W-1:0]  next_cnt;
    logic                       is_wr;
    logic                       next_is_wr;
    logic                       next_req_ready;
    logic                       next_rsp_valid;
    logic [nvs_pkg::DATA_W-1:0] next_rsp_rdata;
    logic                       next_store_busy;
    logic [nvs_pkg::ADDR_W-1:0] next_mem_addr;
    logic                       next_cs_n;
    logic                       next_we_n;
    logic                       next_oe_n;
    logic                       next_ub_n;
    logic                       next_lb_n;
    logic [nvs_pkg::DATA_W-1:0] next_dq_out;
    logic                       next_dq_oe;
    logic                       next_hreq_oe;

    function automatic logic [nvs_pkg::CNT_W-1:0] cyc(input int n);
        cyc = n[nvs_pkg::CNT_W-1:0];
    endfunction

    always_comb begin
        next_state      = state;
        next_cnt        = (cnt == nvs_pkg::CNT_ZERO) ? cnt : cnt - nvs_pkg::CNT_ONE;
        next_is_wr      = is_wr;
        next_req_ready  = 1'b0;
        next_rsp_valid  = 1'b0;
        next_rsp_rdata  = rsp_rdata;
        next_store_busy = !busy_hi || (state == nvs_pkg::NVS_REQ)
                          || (state == nvs_pkg::NVS_WAITHI);
        next_mem_addr   = mem_addr;
        next_cs_n       = chip_select_n;
        next_we_n       = write_strobe_n;
        next_oe_n       = output_drive_n;
        next_ub_n       = upper_byte_lane_n;
        next_lb_n       = lower_byte_lane_n;
        next_dq_out     = dq_out;
        next_dq_oe      = dq_oe;
        next_hreq_oe    = store_busy_request_n_oe;
        unique case (state)
            nvs_pkg::NVS_IDLE: begin
                next_cs_n  = 1'b1;
                next_we_n  = 1'b1;
                next_oe_n  = 1'b1;
                next_dq_oe = 1'b0;
                // No access starts while the device is busy storing.
                if (!busy_hi) begin // [RULE11]
                    next_state = nvs_pkg::NVS_IDLE;
                end else if (store_req) begin
                    next_hreq_oe = 1'b1; // [RULE16]
                    next_state   = nvs_pkg::NVS_REQ;
                end else if (req_valid && !req_ready) begin
                    next_req_ready = 1'b1;
                    next_mem_addr  = req_addr; // [RULE2] [RULE6]
                    next_ub_n      = !req_lanes[1]; // [RULE3] [RULE8]
                    next_lb_n      = !req_lanes[0];
                    next_is_wr     = req_write;
                    next_dq_out    = req_wdata;
                    next_cnt       = cyc(nvs_pkg::SETUP_CYC);
                    next_state     = nvs_pkg::NVS_SETUP;
                end
            end
            nvs_pkg::NVS_SETUP: begin
                // Address is settled one phase before select falls.
                if (cnt == nvs_pkg::CNT_ONE) begin
                    next_cs_n  = 1'b0; // [RULE22]
                    next_we_n  = !is_wr; // [RULE5]
                    next_oe_n  = is_wr; // [RULE1] [RULE9]
                    next_dq_oe = is_wr;
                    next_cnt   = cyc(nvs_pkg::STROBE_CYC + nvs_pkg::SYNC_CYC);
                    next_state = nvs_pkg::NVS_STROBE;
                end
            end
            nvs_pkg::NVS_STROBE: begin
                // Read data is sampled two cycles late through the synchroniser.
                if (cnt == nvs_pkg::CNT_ONE) begin
                    next_cs_n      = 1'b1; // [RULE7]
                    next_we_n      = 1'b1;
                    next_oe_n      = 1'b1; // [RULE23]
                    next_rsp_rdata = is_wr ? rsp_rdata : dq_s2; // [RULE4]
                    next_cnt       = cyc(nvs_pkg::HOLD_CYC);
                    next_state     = nvs_pkg::NVS_HOLD;
                end
            end
            nvs_pkg::NVS_HOLD: begin
                // Data and address stay put past the rising edge.
                if (cnt == nvs_pkg::CNT_ONE) begin
                    next_dq_oe     = 1'b0; // [RULE7]
                    next_rsp_valid = 1'b1;
                    next_state     = nvs_pkg::NVS_IDLE;
                end
            end
            nvs_pkg::NVS_REQ: begin
                // Pull low until the device answers or is seen low; no access meanwhile.
                if (!busy_hi) begin
                    next_hreq_oe = 1'b0; // [RULE20]
                    next_state   = nvs_pkg::NVS_WAITHI;
                end
            end
            nvs_pkg::NVS_WAITHI: begin
                // Device may hold the pin low for the store; wait for release.
                if (busy_hi) begin // [RULE17] [RULE21]
                    next_state = nvs_pkg::NVS_IDLE;
                end
            end
            default: begin
                next_state = nvs_pkg::NVS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state                   <= nvs_pkg::NVS_IDLE;
            cnt                     <= nvs_pkg::CNT_ZERO;
            is_wr                   <= 1'b0;
            req_ready               <= 1'b0;
            rsp_valid               <= 1'b0;
            rsp_rdata               <= '0;
            store_busy              <= 1'b0;
            mem_addr                <= '0;
            chip_select_n           <= 1'b1;
            write_strobe_n          <= 1'b1;
            output_drive_n          <= 1'b1;
            upper_byte_lane_n       <= 1'b1;
            lower_byte_lane_n       <= 1'b1;
            dq_out                  <= '0;
            dq_oe                   <= 1'b0;
            store_busy_request_n_oe <= 1'b0;
        end else begin
            state                   <= next_state;
            cnt                     <= next_cnt;
            is_wr                   <= next_is_wr;
            req_ready               <= next_req_ready;
            rsp_valid               <= next_rsp_valid;
            rsp_rdata               <= next_rsp_rdata;
            store_busy              <= next_store_busy;
            mem_addr                <= next_mem_addr;
            chip_select_n           <= next_cs_n;
            write_strobe_n          <= next_we_n;
            output_drive_n          <= next_oe_n;
            upper_byte_lane_n       <= next_ub_n;
            lower_byte_lane_n       <= next_lb_n;
            dq_out                  <= next_dq_out;
            dq_oe                   <= next_dq_oe;
            store_busy_request_n_oe <= next_hreq_oe;
        end
    end

    // Open drain: only ever drives low.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            store_busy_request_n_out <= 1'b0;
        end else begin
            store_busy_request_n_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: nvs_host_chk.sv
`timescale 1ns/1ps
`default_nettype none
module nvs_host_chk (
    // Clock and reset.
    input wire logic                       clk,
    input wire logic                       rstn,
    // Watched outputs.
    input wire logic                       req_ready,
    input wire logic                       rsp_valid,
    input wire logic                       chip_select_n,
    input wire logic                       write_strobe_n,
    input wire logic                       output_drive_n,
    input wire logic                       dq_oe,
    input wire logic                       store_busy_request_n_oe,
    input wire logic [nvs_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [nvs_pkg::DATA_W-1:0] dq_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Four sampled low cycles: the strobe phase plus the read data synchroniser latency.
    sequence s_strobe_low;
        !write_strobe_n [*4];
    endsequence
    // Data must still be driven at the rising edge that ends the write.
    sequence s_strobe_end;
        write_strobe_n && chip_select_n && dq_oe;
    endsequence
    a_strobe_cs: assert property (!write_strobe_n |-> !chip_select_n)
        else $error("write strobe low without select");
    a_read_ctrl: assert property (!output_drive_n |->
        !chip_select_n && write_strobe_n && !dq_oe)
        else $error("output drive low outside a clean read");
    a_write_drive: assert property (!write_strobe_n |-> output_drive_n && dq_oe)
        else $error("write without host data drive");
    a_addr_hold: assert property (!chip_select_n && $past(!chip_select_n) |->
        $stable(mem_addr) && $stable(dq_out))
        else $error("address or data moved during access");
    a_strobe_len: assert property ($fell(write_strobe_n) |->
        s_strobe_low ##1 s_strobe_end)
        else $error("write strobe length wrong");
    a_ready_rsp: assert property (req_ready |-> ##[5:8] rsp_valid)
        else $error("access not finished in time");
    a_rsp_idle: assert property (rsp_valid |->
        chip_select_n && write_strobe_n && output_drive_n)
        else $error("strobes still active at response");
    a_store_quiet: assert property (store_busy_request_n_oe |->
        chip_select_n && !req_ready)
        else $error("access during store request");
    a_pull_release: assert property ($rose(store_busy_request_n_oe) |->
        ##[1:6] !store_busy_request_n_oe)
        else $error("store request pull not released");
endmodule
bind nvs_host nvs_host_chk u_chk (.clk(clk), .rstn(rstn), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .output_drive_n(output_drive_n), .dq_oe(dq_oe), .mem_addr(mem_addr), .dq_out(dq_out),
    .store_busy_request_n_oe(store_busy_request_n_oe));
`default_nettype wire

// File: nvs_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module nvs_dev_model #(
    parameter int DELAY_NS = 100,
    parameter int STORE_NS = 2000
) (
    // Memory pins.
    input  wire logic [nvs_pkg::ADDR_W-1:0] mem_addr,
    input  wire logic                       chip_select_n,
    input  wire logic                       write_strobe_n,
    input  wire logic                       output_drive_n,
    input  wire logic                       upper_byte_lane_n,
    input  wire logic                       lower_byte_lane_n,
    input  wire logic [nvs_pkg::DATA_W-1:0] dq,
    input  wire logic                       busy_pin,
    input  wire logic                       power_fail,
    input  wire logic                       soft_store,
    // Device drive.
    output logic [nvs_pkg::DATA_W-1:0]      q,
    output logic                            q_en,
    output logic                            busy_pull,
    output int                              n_store
);
    logic [15:0] mem [int];
    logic [15:0] v;
    logic        pend = 1'b0;
    logic        wr_act = 1'b0;
    // Automatic store comes out of reset enabled.
    localparam bit AUTO_EN = 1'b1;
    initial begin
        busy_pull = 1'b0;
        n_store = 0;
    end
    // Disabled lanes show the inverse so a stale byte never passes.
    always @* begin
        v = mem.exists(int'(mem_addr)) ? mem[int'(mem_addr)] : 16'h0000;
        q = {upper_byte_lane_n ? ~v[15:8] : v[15:8],
             lower_byte_lane_n ? ~v[7:0] : v[7:0]};
        q_en = !chip_select_n && !output_drive_n && write_strobe_n
               && busy_pin && !busy_pull
               && !(upper_byte_lane_n && lower_byte_lane_n);
    end
    always @(negedge chip_select_n or negedge write_strobe_n)
        wr_act = !chip_select_n && !write_strobe_n && busy_pin && !busy_pull;
    always @(posedge chip_select_n or posedge write_strobe_n) if (wr_act) begin
        v = mem.exists(int'(mem_addr)) ? mem[int'(mem_addr)] : 16'h0000;
        mem[int'(mem_addr)] = {upper_byte_lane_n ? v[15:8] : dq[15:8],
                               lower_byte_lane_n ? v[7:0] : dq[7:0]};
        pend = 1'b1;
        wr_act = 1'b0;
    end
    always @(negedge busy_pin) if (!busy_pull) begin
        #DELAY_NS;
        if (pend) begin
            busy_pull = 1'b1;
            #STORE_NS;
            pend = 1'b0;
            n_store++;
            busy_pull = 1'b0;
        end
    end
    // Power fail and software store run the same store; only software skips the write test.
    always @(posedge power_fail or posedge soft_store)
        if (!busy_pull && (soft_store || (AUTO_EN && pend))) begin
            busy_pull = 1'b1;
            #STORE_NS;
            pend = 1'b0;
            n_store++;
            busy_pull = 1'b0;
        end
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic req_valid = 1'b0, req_write = 1'b0, store_req = 1'b0;
    logic power_fail = 1'b0, soft_store = 1'b0;
    logic [17:0] req_addr = '0;
    logic [15:0] req_wdata = '0;
    logic [1:0] req_lanes = '0;
    logic req_ready, rsp_valid, store_busy, dq_oe, hsb_out, hsb_oe, q_en, busy_pull;
    logic chip_select_n, write_strobe_n, output_drive_n, upper_byte_lane_n, lower_byte_lane_n;
    logic [17:0] mem_addr;
    logic [15:0] rsp_rdata, dq_out, q;
    logic [15:0] shadow [int];
    int n_store, n_mismatch = 0, tests_run = 0, cyc = 0;
    // Open drain busy line with pull-up; undriven data toggles on every clock edge.
    wire busy_pin = !((hsb_oe && !hsb_out) || busy_pull);
    wire [15:0] dq_in = dq_oe ? dq_out : (q_en ? q : 16'hA5C3 ^ {16{clk}});
    always #25 clk = ~clk;
    nvs_host DUT (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes), .store_req(store_req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .store_busy(store_busy),
        .mem_addr(mem_addr), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
        .output_drive_n(output_drive_n), .upper_byte_lane_n(upper_byte_lane_n),
        .lower_byte_lane_n(lower_byte_lane_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .store_busy_request_n_in(busy_pin), .store_busy_request_n_out(hsb_out),
        .store_busy_request_n_oe(hsb_oe));
    nvs_dev_model u_dev (.mem_addr(mem_addr), .chip_select_n(chip_select_n),
        .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
        .upper_byte_lane_n(upper_byte_lane_n), .lower_byte_lane_n(lower_byte_lane_n), .dq(dq_in),
        .busy_pin(busy_pin), .q(q), .q_en(q_en), .busy_pull(busy_pull), .n_store(n_store),
        .power_fail(power_fail), .soft_store(soft_store));
    function automatic logic [15:0] mask(input logic [1:0] ln);
        return {{8{ln[1]}}, {8{ln[0]}}};
    endfunction
    function automatic logic [15:0] get(input logic [17:0] a);
        return shadow.exists(int'(a)) ? shadow[int'(a)] : 16'h0000;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_for(input logic sig_is_ready);
        int n;
        n = 0;
        do begin @(posedge clk); #1; n++; end
        while ((sig_is_ready ? req_ready : rsp_valid) !== 1'b1 && n < 100);
        if (n >= 100) chk(32'h0, 32'h1);
    endtask
    task automatic access(input logic w, input logic [17:0] a, input logic [15:0] d,
                          input logic [1:0] ln);
        @(posedge clk); #1;
        {req_valid, req_write, req_addr, req_wdata, req_lanes} = {1'b1, w, a, d, ln};
        wait_for(1'b1);
        req_valid = 1'b0;
        wait_for(1'b0);
        if (w) shadow[int'(a)] = (get(a) & ~mask(ln)) | (d & mask(ln));
    endtask
    task automatic rd_chk(input logic [17:0] a, input logic [1:0] ln);
        access(1'b0, a, 16'h0000, ln);
        chk(rsp_rdata & mask(ln), get(a) & mask(ln));
    endtask
    // Source 0 is the host pin request, 1 a power fail, 2 a software store.
    task automatic store(input int src, input int exp_count);
        int n;
        @(posedge clk); #1;
        {soft_store, power_fail, store_req} = 3'b001 << src;
        n = 0;
        do begin @(posedge clk); #1; n++; end while (store_busy !== 1'b1 && n < 20);
        {soft_store, power_fail, store_req} = 3'b000;
        do begin @(posedge clk); #1; n++; end while ((store_busy !== 1'b0 || !busy_pin) && n < 200);
        if (n >= 200) chk(32'h0, 32'h1);
        chk(n_store, exp_count);
    endtask
    task report_and_stop;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        logic [17:0] a;
        void'($urandom(58));
        repeat (4) @(posedge clk);
        #1 rstn = 1'b1;
        // Boundary addresses, lane merge on one word, then random traffic.
        access(1'b1, 18'h00000, 16'hFFFF, 2'b11);
        access(1'b1, 18'h00000, 16'h1234, 2'b01);
        rd_chk(18'h00000, 2'b11);
        access(1'b1, 18'h3FFFF, 16'h5AA5, 2'b10);
        rd_chk(18'h3FFFF, 2'b11);
        for (int i = 0; i < 20; i++) begin
            a = 18'($urandom);
            access(1'b1, a, 16'($urandom), 2'($urandom_range(1, 3)));
            rd_chk(a, 2'($urandom_range(1, 3)));
        end
        store(0, 1);
        store(0, 1);
        rd_chk(18'h00000, 2'b11);
        access(1'b1, 18'h00010, 16'hC33C, 2'b11);
        store(0, 2);
        rd_chk(18'h00010, 2'b11);
        // Power fail store with a read queued behind it, then each source without a write.
        access(1'b1, 18'h00020, 16'h0F0F, 2'b11);
        power_fail = 1'b1;
        repeat (3) @(posedge clk);
        #1 power_fail = 1'b0;
        rd_chk(18'h00020, 2'b11);
        chk(n_store, 3);
        store(1, 3);
        store(2, 4);
        store(0, 4);
        rd_chk(18'h00020, 2'b11);
        report_and_stop();
    end
endmodule
`default_nettype wire
